// ==== bench/code_data_memory_programmer_checker.sv ====
// pin-level checks of the code and data memory programmer
module code_data_memory_programmer_checker (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic rst_pin,
   input wire logic prog_strobe_n,
   input wire logic program_store_strobe_n,
   input wire logic ext_access_prog_voltage,
   input wire logic mode_select_a,
   input wire logic verify_select_line,
   input wire logic mode_select_c,
   input wire logic mode_select_d,
   input wire logic [7:0] addr_low,
   input wire logic [5:0] addr_high,
   input wire logic data_oe_n,
   input wire logic ready_busy_out,
   input wire logic sck,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire logic lock_level_one,
   input wire logic lock_level_three,
   input wire logic code_table_read_block,
   input wire logic ext_exec_block,
   input wire logic serial_prog_disabled
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic [15:0] busy_cnt;
   wire [3:0] mode = {mode_select_a, verify_select_line, mode_select_c,
      mode_select_d};
   wire [13:0] addr = {addr_high, addr_low};
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         busy_cnt <= 16'h0000;
      else if (ready_busy_out)
         busy_cnt <= 16'h0000;
      else
         busy_cnt <= busy_cnt + 16'h0001;
   property p_lock_one;
      $rose(lock_level_one) |-> ##[0:2] code_table_read_block;
   endproperty
   a_lock_one: assert property (p_lock_one)
      else $error("table read block missing after lock one");
   property p_lock_three;
      $rose(lock_level_three) |-> ##[0:2] ext_exec_block;
   endproperty
   a_lock_three: assert property (p_lock_three)
      else $error("external execution block missing after lock three");
   property p_busy_min;
      $fell(ready_busy_out) |-> !ready_busy_out [*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("busy ended too soon");
   property p_busy_max;
      busy_cnt < 16'h32C8;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("busy never ended");
   property p_busy_start;
      $rose(prog_strobe_n) && !program_store_strobe_n && rst_pin &&
         ext_access_prog_voltage && mode == 4'h7 && addr <= 14'h27FF &&
         ready_busy_out && !lock_level_one |-> ##[2:6] !ready_busy_out;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("write strobe did not raise busy");
   property p_miso_fall;
      $changed(miso) && !miso_oe_n && $stable(miso_oe_n) |-> !$past(sck, 2);
   endproperty
   a_miso_fall: assert property (p_miso_fall)
      else $error("serial output moved while clock high");
   property p_par_quiet;
      program_store_strobe_n [*5] |-> data_oe_n;
   endproperty
   a_par_quiet: assert property (p_par_quiet)
      else $error("data port driven outside parallel mode");
   property p_ser_fuse;
      serial_prog_disabled [*5] |-> miso_oe_n;
   endproperty
   a_ser_fuse: assert property (p_ser_fuse)
      else $error("serial output driven with serial fuse set");
endmodule

bind code_data_memory_programmer code_data_memory_programmer_checker
   u_code_data_memory_programmer_checker (.*);

// ==== bench/code_data_memory_programmer_test.sv ====
// self-checking bench for the code and data memory programmer
module code_data_memory_programmer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, arst_n = 1'b0, rst_pin = 1'b1, strobe_n = 1'b1;
   logic pss_n = 1'b0, vpp = 1'b1;
   logic [3:0] mode = 4'h3;
   logic [13:0] addr = 14'h0000;
   logic [7:0] din = 8'h00, rd;
   logic [7:0] mem [int];
   logic [13:0] at [6] = '{14'h0000, 14'h1FFF, 14'h2000, 14'h27FF,
      14'h0000, 14'h2000};
   wire [7:0] data_out;
   wire data_oe_n, ready_busy_out, sck, mosi, miso, miso_oe_n;
   wire lk1, lk2, lk3, ctr_blk, ext_blk, sp_dis, ea_lat;
   int failures = 0, cmp_count = 0, i;
   logic [31:0] seed = 32'hD469A0C4;
   initial forever #50 clk_sys = ~clk_sys;
   code_data_memory_programmer #(.WRITE_CYCLES(18'h14),
      .ERASE_HOLD_CYCLES(18'h1E), .SER_ERASE_CYCLES(18'h2EE0))
   u_code_data_memory_programmer (.clk_sys(clk_sys), .arst_n(arst_n),
      .rst_pin(rst_pin), .prog_strobe_n(strobe_n),
      .program_store_strobe_n(pss_n), .ext_access_prog_voltage(vpp),
      .mode_select_a(mode[3]), .verify_select_line(mode[2]),
      .mode_select_c(mode[1]), .mode_select_d(mode[0]),
      .addr_low(addr[7:0]), .addr_high(addr[13:8]), .data_in(din),
      .data_out(data_out), .data_oe_n(data_oe_n),
      .ready_busy_out(ready_busy_out), .sck(sck), .mosi(mosi), .miso(miso),
      .miso_oe_n(miso_oe_n), .lock_level_one(lk1), .lock_level_two(lk2),
      .lock_level_three(lk3), .code_table_read_block(ctr_blk),
      .ext_exec_block(ext_blk), .ea_latched(ea_lat),
      .serial_prog_disabled(sp_dis));
   serial_host_model u_serial_host_model (.clk_sys(clk_sys), .sck(sck),
      .mosi(mosi), .miso(miso));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] exp_byte(input logic [13:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   function automatic logic [23:0] ins(input logic dsp, wr,
         input logic [12:0] a, input logic [7:0] d);
      return {dsp ? {2'b00, a[10:8]} : a[12:8], dsp, wr, ~wr, a[7:0],
         wr ? d : 8'h00};
   endfunction
   task automatic chk8(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wait_ready;
      int k;
      for (k = 0; k < 13000 && ready_busy_out !== 1'b1; k++)
         cyc(1);
   endtask
   task automatic par_read(input logic [3:0] m, input logic [13:0] a);
      mode <= m;
      addr <= a;
      cyc(8);
      rd = data_out;
   endtask
   task automatic par_op(input logic [3:0] m, input logic [7:0] d, int h);
      mode <= m;
      din <= d;
      cyc(4);
      strobe_n <= 1'b0;
      cyc(h);
      strobe_n <= 1'b1;
      cyc(8);
      wait_ready;
      cyc(4);
   endtask
   task automatic par_write(input logic [13:0] a, input logic [7:0] d);
      logic [7:0] e;
      e = exp_byte(a) & d;
      mode <= 4'h7;
      addr <= a;
      din <= d;
      cyc(4);
      strobe_n <= 1'b0;
      cyc(3);
      strobe_n <= 1'b1;
      cyc(6);
      chk1(ready_busy_out, 1'b0);
      mode <= 4'h3;
      cyc(6);
      // bits below the top one are only certain for a blank location
      if (exp_byte(a) === 8'hFF)
         chk8(data_out, {~d[7], d[6:0]});
      wait_ready;
      cyc(8);
      chk8(data_out, e);
      mem[a] = e;
   endtask
   task automatic ser(input logic [23:0] x);
      u_serial_host_model.xfer(x, rd);
      cyc(30);
   endtask
   task automatic fin(input string s);
      $display("test %s finished", s);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      print_verdict;
   end
   initial begin
      cyc(6);
      arst_n <= 1'b1;
      cyc(8);
      chk1(ready_busy_out, 1'b1);
      chk1(lk1, 1'b0);
      chk1(ea_lat, 1'b1);
      seed = xs(seed);
      par_read(4'h3, {1'b0, seed[12:0]});
      chk8(rd, 8'hFF);
      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         par_write(at[i], seed[7:0]);
      end
      par_read(4'h3, 14'h2800);
      chk8(rd, 8'hFF);
      par_read(4'h0, 14'h0030);
      chk8(rd, 8'h5A);
      par_read(4'h0, 14'h0031);
      chk8(rd, 8'hC3);
      fin("parallel");
      par_op(4'h5, 8'h01, 3);
      chk1(sp_dis, 1'b1);
      pss_n <= 1'b1;
      cyc(10);
      chk1(miso_oe_n, 1'b1);
      pss_n <= 1'b0;
      par_op(4'h5, 8'h00, 3);
      chk1(sp_dis, 1'b0);
      par_read(4'hD, 14'h0000);
      chk8(rd, 8'hFE);
      par_op(4'h8, 8'h00, 40);
      mem.delete();
      par_read(4'h3, 14'h1FFF);
      chk8(rd, 8'hFF);
      fin("fuse and erase");
      pss_n <= 1'b1;
      cyc(10);
      ser(ins(1'b0, 1'b0, 13'h0000, 8'h00));
      chk8(rd, 8'h00);
      ser(24'hAC5300);
      seed = xs(seed);
      ser(ins(1'b0, 1'b1, 13'h0000, seed[7:0]));
      ser(ins(1'b0, 1'b0, 13'h0000, 8'h00));
      chk8(rd, seed[7:0]);
      ser(ins(1'b1, 1'b1, 13'h07FF, seed[15:8]));
      ser(ins(1'b1, 1'b0, 13'h07FF, 8'h00));
      chk8(rd, seed[15:8]);
      ser({8'hAC, seed[23:19], 3'h4, seed[31:24]});
      ser(ins(1'b1, 1'b0, 13'h0123, 8'h00));
      chk8(rd, 8'h00);
      cyc(12000);
      ser(ins(1'b0, 1'b0, 13'h0000, 8'h00));
      chk8(rd, 8'hFF);
      fin("serial");
      ser(24'hAC1F00);
      chk1(lk1 & lk2 & lk3, 1'b1);
      chk1(ctr_blk & ext_blk, 1'b1);
      ser(ins(1'b0, 1'b0, 13'h0000, 8'h00));
      chk8(rd, 8'hFF);
      pss_n <= 1'b0;
      cyc(10);
      par_read(4'hC, 14'h0000);
      chk8(rd, 8'hF8);
      par_read(4'h3, 14'h2000);
      chk8(rd, 8'hFF);
      fin("lock");
      print_verdict;
   end
endmodule

// ==== bench/serial_host_model.sv ====
// serial programming host that clocks three-byte instructions
module serial_host_model (
   input wire logic clk_sys,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   // four clocks low and four high: an 800 ns link period
   task automatic xfer(input logic [23:0] ins, output logic [7:0] rep);
      int i;
      rep = 8'h00;
      for (i = 23; i >= 0; i--) begin
         @(posedge clk_sys);
         mosi <= ins[i];
         repeat (3) @(posedge clk_sys);
         sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         // reply bit lags the falling edge, so take it late in the high phase
         if (i < 8)
            rep = {rep[6:0], miso};
         sck <= 1'b0;
      end
      @(posedge clk_sys);
      // leave no stale bit on the line between frames
      mosi <= ~mosi;
   endtask
endmodule

// ==== rtl/byte_store.v ====
// byte array holding code and data contents, registered read
`include "prog_defs.vh"
module byte_store #(
   parameter DEPTH = `MEM_DEPTH,
   parameter AW = `ADDR_W
)(
   input wire clk_sys,
   input wire we,
   input wire [AW-1:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:DEPTH-1];
   integer i;
   wire in_range = ({1'b0, addr} < DEPTH);

   // arrays leave the factory erased
   initial begin
      for (i = 0; i < DEPTH; i = i + 1) begin
         mem[i] = `ERASED_BYTE;
      end
   end

   always @(posedge clk_sys) begin
      if (we && in_range) begin
         mem[addr] <= wdata;
      end
      rdata <= in_range ? mem[addr] : `ERASED_BYTE;
   end
endmodule

// ==== rtl/code_data_memory_programmer.v ====
// parallel and serial programming logic for code and data arrays
//
// How it works
// - lock level one blocks external table reads and stops writes; access pin latched at every lock level
// - lock level two also refuses read-back in both modes
// - lock level three also blocks execution from external memory
// - erased and delivered bytes read as all ones
// - parallel map: code up to 1FFFH, data 2000H to 27FFH
// - serial map: code 0000H-1FFFH, data 000H-7FFH, separate spaces
// - serial byte writes erase the location first
// - one strobe pulse starts a self-timed byte write of about 1.5 ms
// - verify line low presents the stored byte on the data port
// - polling the byte under write returns its top bit inverted
// - ready/busy goes low after strobe rises, high when done
// - lock bits readable in parallel mode, never through serial
// - strobe held low 10 ms in erase mode erases both arrays
// - serial chip erase is self-timed, about 16 ms
// - any serial read during chip erase returns all zeros
// - serial fuse disables serial mode; changed only in parallel mode
// - signature read at 030H and 031H gives maker and part codes
// - after reset rises, only the enable instruction is accepted first
// - instructions are three bytes; enable is ACh, 53h, ignored byte
// - chip erase is ACh then a byte ending in 100
`include "prog_defs.vh"
module code_data_memory_programmer #(
   parameter [17:0] WRITE_CYCLES =
      (`WRITE_TIME_US * 1000) / `CLK_PERIOD_NS,
   parameter [17:0] ERASE_HOLD_CYCLES =
      (`PAR_ERASE_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter [17:0] SER_ERASE_CYCLES =
      (`SER_ERASE_TIME_US * 1000) / `CLK_PERIOD_NS,
   parameter [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter [7:0] PART_CODE = 8'hC3 // arbitrary value
)(
   input wire clk_sys,
   input wire arst_n,
   input wire rst_pin,
   input wire prog_strobe_n,
   input wire program_store_strobe_n,
   input wire ext_access_prog_voltage,
   input wire mode_select_a,
   input wire verify_select_line,
   input wire mode_select_c,
   input wire mode_select_d,
   input wire [7:0] addr_low,
   input wire [5:0] addr_high,
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg data_oe_n,
   output reg ready_busy_out,
   input wire sck,
   input wire mosi,
   output reg miso,
   output reg miso_oe_n,
   output reg lock_level_one,
   output reg lock_level_two,
   output reg lock_level_three,
   output reg code_table_read_block,
   output reg ext_exec_block,
   output reg ea_latched,
   output reg serial_prog_disabled
);
   localparam ST_IDLE = 3'h0;
   localparam ST_WR_READ = 3'h1;
   localparam ST_WR_MERGE = 3'h2;
   localparam ST_WAIT = 3'h3;
   localparam ST_ERASE = 3'h4;
   localparam [31:0] PIN_RST = `PIN_RESET;
   localparam [13:0] LAST_ADDR = `MEM_DEPTH - 1;

   reg [1:0] rst_sync;
   wire rst_n = rst_sync[1];
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   wire [31:0] pin_raw = {rst_pin, prog_strobe_n, program_store_strobe_n,
      ext_access_prog_voltage, mode_select_a, verify_select_line,
      mode_select_c, mode_select_d, sck, mosi, addr_high, addr_low,
      data_in};
   reg [31:0] meta;
   reg [31:0] pins;
   genvar g;
   generate
      for (g = 0; g < `NUM_PINS; g = g + 1) begin : sync
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               meta[g] <= PIN_RST[g];
               pins[g] <= PIN_RST[g];
            end else begin
               meta[g] <= pin_raw[g];
               pins[g] <= meta[g];
            end
         end
      end
   endgenerate

   wire rst_pin_s = pins[31];
   wire strobe_n_s = pins[30];
   wire program_store_strobe_n_n_s = pins[29];
   wire vpp_s = pins[28];
   wire [3:0] pmode = pins[27:24];
   wire sck_s = pins[23];
   wire mosi_s = pins[22];
   wire [13:0] par_addr = pins[21:8];
   wire [7:0] par_din = pins[7:0];

   reg [2:0] state;
   reg [17:0] timer;
   reg [13:0] walk;
   reg [13:0] wr_addr;
   reg [7:0] wr_data;
   reg wr_merge;
   reg op_erase;
   reg poll_ok;
   reg [2:0] lock;
   reg ser_en;
   reg [7:0] b1;
   reg [7:0] b2;
   reg [13:0] ser_addr;
   reg ser_rd_ok;
   reg [7:0] tx_byte;
   reg strobe_d;
   reg [17:0] hold_cnt;
   reg erase_fired;

   wire byte_done;
   wire [1:0] byte_idx;
   wire [7:0] rx_byte;
   wire miso_bit;
   wire [7:0] rdata;
   reg mem_we;
   reg [13:0] mem_addr;
   reg [7:0] mem_wdata;

   // programming voltage must be up for any parallel work
   wire par_act = rst_pin_s & ~program_store_strobe_n_n_s & vpp_s;
   wire ser_act = rst_pin_s & program_store_strobe_n_n_s & ~serial_prog_disabled;
   wire idle = (state == ST_IDLE);
   wire busy = ~idle;
   wire strobe_rise = strobe_n_s & ~strobe_d;
   wire par_mapped = (par_addr <= `DATA_TOP);
   wire [13:0] rd_addr = par_act ? par_addr : ser_addr;
   wire polling = busy & poll_ok & (rd_addr == wr_addr);
   // while a write runs the array port is taken, only polling answers
   wire [7:0] rd_val = polling ? {~wr_data[7], wr_data[6:0]} :
      (busy ? `ERASED_BYTE : rdata);
   wire erasing = busy & op_erase;

   wire par_wr_go = par_act & strobe_rise & idle & (pmode == `PM_WRITE) &
      par_mapped & ~lock[0];
   wire par_lock_go = par_act & strobe_rise & idle &
      (pmode == `PM_WR_LOCK);
   wire par_fuse_go = par_act & strobe_rise & idle & (pmode == `PM_FUSE);
   wire par_erase_go = par_act & idle & ~strobe_n_s & ~erase_fired &
      (pmode == `PM_ERASE) & (hold_cnt >= ERASE_HOLD_CYCLES);

   wire ser_go = ser_act & byte_done & (byte_idx == 2'h2) & idle;
   wire ser_prefix = (b1 == `CMD_PREFIX);
   wire ser_enable_cmd = ser_prefix & (b2 == `CMD_ENABLE);
   wire ser_erase_go = ser_go & ser_en & ser_prefix &
      (b2[2:0] == `CMD_ERASE_SEL);
   wire ser_lock_go = ser_go & ser_en & ser_prefix &
      (b2[2:0] == `CMD_LOCK_SEL);
   wire ser_wr_go = ser_go & ser_en & ~lock[0] &
      ((b1[2:0] == `OP_WR_CODE) | (b1[2:0] == `OP_WR_DATA));
   wire ser_rd_op = (b1[2:0] == `OP_RD_CODE) | (b1[2:0] == `OP_RD_DATA);
   wire [13:0] ser_next_addr = b1[`OP_DATA_BIT] ?
      (`DATA_BASE + {3'h0, b1[5:3], rx_byte}) : {1'b0, b1[7:3], rx_byte};

   always @* begin
      mem_we = 1'b0;
      mem_addr = rd_addr;
      mem_wdata = wr_data;
      if (state == ST_WR_READ) begin
         mem_addr = wr_addr;
      end else if (state == ST_WR_MERGE) begin
         mem_addr = wr_addr;
         mem_we = 1'b1;
         // parallel writes can only clear bits
         mem_wdata = wr_merge ? (rdata & wr_data) : wr_data;
      end else if (state == ST_ERASE) begin
         mem_addr = walk;
         mem_we = 1'b1;
         mem_wdata = `ERASED_BYTE;
      end
   end

   byte_store #(
      .DEPTH(`MEM_DEPTH),
      .AW(`ADDR_W)
   ) store (
      .clk_sys(clk_sys),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(rdata)
   );

   spi_byte_link link (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .frame_clr(~ser_act),
      .sck_s(sck_s),
      .mosi_s(mosi_s),
      .tx_byte(tx_byte),
      .byte_done(byte_done),
      .byte_idx(byte_idx),
      .rx_byte(rx_byte),
      .miso_bit(miso_bit)
   );

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         timer <= 18'h0;
         walk <= 14'h0;
         wr_addr <= 14'h0;
         wr_data <= 8'h00;
         wr_merge <= 1'b0;
         op_erase <= 1'b0;
         poll_ok <= 1'b0;
         lock <= 3'h0;
         serial_prog_disabled <= 1'b0;
         ser_en <= 1'b0;
         b1 <= 8'h00;
         b2 <= 8'h00;
         ser_addr <= 14'h0;
         ser_rd_ok <= 1'b0;
         strobe_d <= 1'b1;
         hold_cnt <= 18'h0;
         erase_fired <= 1'b0;
      end else begin
         strobe_d <= strobe_n_s;
         if (strobe_n_s || !par_act || pmode != `PM_ERASE) begin
            hold_cnt <= 18'h0;
         end else if (hold_cnt < ERASE_HOLD_CYCLES) begin
            hold_cnt <= hold_cnt + 18'h1;
         end
         if (strobe_n_s) begin
            erase_fired <= 1'b0;
         end
         // enable is forgotten whenever reset drops
         if (!rst_pin_s) begin
            ser_en <= 1'b0;
         end else if (ser_go && ser_enable_cmd) begin
            ser_en <= 1'b1;
         end
         if (ser_act && byte_done && byte_idx == 2'h0) begin
            b1 <= rx_byte;
         end
         if (ser_act && byte_done && byte_idx == 2'h1) begin
            b2 <= rx_byte;
            ser_addr <= ser_next_addr;
            ser_rd_ok <= ser_en & ser_rd_op;
         end
         case (state)
            ST_IDLE: begin
               if (par_wr_go || ser_wr_go) begin
                  wr_addr <= par_wr_go ? par_addr : ser_addr;
                  wr_data <= par_wr_go ? par_din : rx_byte;
                  // serial write overwrites the byte outright
                  wr_merge <= par_wr_go;
                  op_erase <= 1'b0;
                  poll_ok <= 1'b1;
                  timer <= WRITE_CYCLES;
                  state <= ST_WR_READ;
               end else if (par_lock_go || ser_lock_go) begin
                  lock <= lock | (par_lock_go ? ~par_din[7:5] : ~b2[7:5]);
                  op_erase <= 1'b0;
                  poll_ok <= 1'b0;
                  timer <= WRITE_CYCLES;
                  state <= ST_WAIT;
               end else if (par_fuse_go) begin
                  // fuse reachable only from the parallel side
                  serial_prog_disabled <= par_din[0];
                  op_erase <= 1'b0;
                  poll_ok <= 1'b0;
                  timer <= WRITE_CYCLES;
                  state <= ST_WAIT;
               end else if (par_erase_go || ser_erase_go) begin
                  erase_fired <= par_erase_go;
                  lock <= 3'h0;
                  walk <= 14'h0;
                  op_erase <= 1'b1;
                  poll_ok <= 1'b0;
                  // hold time already spent on the parallel side
                  timer <= par_erase_go ? 18'h1 : SER_ERASE_CYCLES;
                  state <= ST_ERASE;
               end
            end
            ST_WR_READ: begin
               timer <= timer - 18'h1;
               state <= ST_WR_MERGE;
            end
            ST_WR_MERGE: begin
               timer <= timer - 18'h1;
               state <= ST_WAIT;
            end
            ST_ERASE: begin
               if (timer > 18'h1) begin
                  timer <= timer - 18'h1;
               end
               walk <= walk + 14'h1;
               if (walk == LAST_ADDR) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (timer <= 18'h1) begin
                  timer <= 18'h0;
                  op_erase <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 18'h1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte <= 8'h00;
         data_out <= `ERASED_BYTE;
         data_oe_n <= 1'b1;
         ready_busy_out <= 1'b1;
         miso <= 1'b0;
         miso_oe_n <= 1'b1;
         lock_level_one <= 1'b0;
         lock_level_two <= 1'b0;
         lock_level_three <= 1'b0;
         code_table_read_block <= 1'b0;
         ext_exec_block <= 1'b0;
         ea_latched <= 1'b0;
      end else begin
         if (erasing) begin
            tx_byte <= `ERASING_READ;
         end else if (!ser_rd_ok) begin
            tx_byte <= 8'h00; // no lock-bit read over the serial link
         end else if (lock[1]) begin
            tx_byte <= `ERASED_BYTE;
         end else begin
            tx_byte <= rd_val;
         end
         case (pmode)
            `PM_READ:
               data_out <= (lock[1] || !par_mapped) ? `ERASED_BYTE :
                  rd_val;
            `PM_RD_LOCK:
               data_out <= {5'h1F, ~lock[0], ~lock[1], ~lock[2]};
            `PM_SIG:
               data_out <= (par_addr == `SIG_MAKER_ADDR) ? MAKER_CODE :
                  (par_addr == `SIG_PART_ADDR) ? PART_CODE :
                  `ERASED_BYTE;
            `PM_RD_FUSE:
               data_out <= {7'h7F, serial_prog_disabled};
            default:
               data_out <= `ERASED_BYTE;
         endcase
         data_oe_n <= ~(par_act && (pmode == `PM_READ ||
            pmode == `PM_RD_LOCK || pmode == `PM_SIG ||
            pmode == `PM_RD_FUSE));
         // busy follows the synchronised strobe's rising edge by two cycles
         ready_busy_out <= ~busy | ~par_act;
         miso <= miso_bit;
         miso_oe_n <= ~ser_act;
         lock_level_one <= lock[0];
         lock_level_two <= lock[1];
         lock_level_three <= lock[2];
         code_table_read_block <= lock[0];
         ext_exec_block <= lock[2];
         // access pin caught while the device is held in reset
         if (rst_pin_s) begin
            ea_latched <= vpp_s;
         end
      end
   end
endmodule

// ==== rtl/prog_defs.vh ====
// shared constants of the code and data memory programmer
`ifndef PROG_DEFS_VH
`define PROG_DEFS_VH

// timing, printed figures in their own units
`define CLK_PERIOD_NS 100
`define WRITE_TIME_US 1500
`define PAR_ERASE_HOLD_US 10000
`define SER_ERASE_TIME_US 16000
`define TIMER_W 18

// memory layout
`define MEM_DEPTH 10240
`define ADDR_W 14
`define DATA_BASE 14'h2000
`define DATA_TOP 14'h27FF
`define ERASED_BYTE 8'hFF
`define ERASING_READ 8'h00
`define SIG_MAKER_ADDR 14'h0030
`define SIG_PART_ADDR 14'h0031

// serial instruction encodings
`define CMD_PREFIX 8'hAC
`define CMD_ENABLE 8'h53
`define CMD_ERASE_SEL 3'h4
`define CMD_LOCK_SEL 3'h7
`define OP_RD_CODE 3'h1
`define OP_WR_CODE 3'h2
`define OP_RD_DATA 3'h5
`define OP_WR_DATA 3'h6
`define OP_DATA_BIT 2

// parallel mode select {a, verify, c, d}
`define PM_ERASE 4'h8
`define PM_WRITE 4'h7
`define PM_READ 4'h3
`define PM_WR_LOCK 4'hA
`define PM_RD_LOCK 4'hC
`define PM_SIG 4'h0
`define PM_FUSE 4'h5
`define PM_RD_FUSE 4'hD

// synchroniser reset image: strobe and store strobe idle high
`define PIN_RESET 32'h6000_0000
`define NUM_PINS 32

`endif

// ==== rtl/spi_byte_link.v ====
// serial byte shifter, link clock sampled as plain synchronised input
module spi_byte_link (
   input wire clk_sys,
   input wire rst_n,
   input wire frame_clr,
   input wire sck_s,
   input wire mosi_s,
   input wire [7:0] tx_byte,
   output reg byte_done,
   output reg [1:0] byte_idx,
   output reg [7:0] rx_byte,
   output wire miso_bit
);
   reg sck_d;
   reg [2:0] bit_cnt;
   reg [1:0] cnt_byte;
   reg [7:0] in_sr;
   reg [7:0] out_sr;
   wire rise = sck_s & ~sck_d;
   wire fall = ~sck_s & sck_d;

   assign miso_bit = out_sr[7];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sck_d <= 1'b0;
         bit_cnt <= 3'h0;
         cnt_byte <= 2'h0;
         in_sr <= 8'h00;
         out_sr <= 8'h00;
         byte_done <= 1'b0;
         byte_idx <= 2'h0;
         rx_byte <= 8'h00;
      end else begin
         sck_d <= sck_s;
         byte_done <= 1'b0;
         if (frame_clr) begin
            bit_cnt <= 3'h0;
            cnt_byte <= 2'h0;
            out_sr <= 8'h00;
         end else if (rise) begin
            // msb first, sampled on rising edge
            in_sr <= {in_sr[6:0], mosi_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               byte_done <= 1'b1;
               byte_idx <= cnt_byte;
               rx_byte <= {in_sr[6:0], mosi_s};
               // three bytes to an instruction
               cnt_byte <= (cnt_byte == 2'h2) ? 2'h0 :
                  cnt_byte + 2'h1;
            end
         end else if (fall) begin
            // output changes on falling edge; reply only in third byte
            if (bit_cnt == 3'h0) begin
               out_sr <= (cnt_byte == 2'h2) ? tx_byte : 8'h00;
            end else begin
               out_sr <= {out_sr[6:0], 1'b0};
            end
         end
      end
   end
endmodule
